// ### dfd_dev.sv
/*
 * Device end: receives frames, decodes them and updates the per-channel
 * code, gain, offset, clear-code and control registers.
 * Assumes link pins are asynchronous to hclk and that the serial clock
 * phase lasts at least three hclk cycles.
 */
// Functional notes
// [R1] Host resets device before any configuration
// [R2] Host sets converter frequency, voltage, phase first
// [R3] Host writes channel control, output drive off
// [R4] Code write starts channel calibration
// [R5] Host waits 200 us before output enable
// [R6] Host rewrites channel control with output on
// [R7] Range change repeats setup, zero point first
// [R8] Converter settings survive a range change
// [R9] Frame is 24 bits, 32 with check
// [R10] Fields: rw, device, group, channel, data
// [R11] Act only when device select matches straps
// [R12] Groups 000 code, 010 gain, 011 all
// [R13] Control group decodes a control select field
// [R14] Groups 100/101 offset, 110 clear, 111 control
// [R15] Channel select picks A to D
// [R16] MSB first, apply only complete frames
`timescale 1ns/1ps
module dfd_dev
   import dfd_pkg::*;
#(
   parameter int CAL_CYC = dfd_pkg::CAL_CYCLES
) (
   // System
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Link
   dfd_link_if.dev          link,
   // Address straps
   input  wire logic        strap_pin_hi,
   input  wire logic        strap_pin_lo,
   // Register contents, channel A in the low 16 bits
   output logic      [63:0] chan_code,
   output logic      [63:0] chan_gain,
   output logic      [63:0] chan_offset,
   output logic      [63:0] chan_clear,
   output logic      [63:0] chan_ctrl,
   output logic      [63:0] chan_slew,
   output logic      [15:0] main_ctrl,
   output logic      [15:0] dcdc_ctrl,
   // Status
   output logic       [3:0] cal_busy,
   output logic             check_on,
   output logic             frame_applied,
   output logic             frame_dropped
);
   import dfd_pkg::*;

   localparam int CW = $clog2(CAL_CYC + 1);

   // Pin synchronisers: reset, select, clock, data, straps
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic       rstpin_s;
   logic       sel_s;
   logic       sclk_s;
   logic       sdin_s;
   logic [1:0] strap_s;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 6'h3c;
         pin_s2 <= 6'h3c;
      end else begin
         pin_s1 <= {link.reset_n, link.sync_n, link.sclk, link.sdin,
                    strap_pin_hi, strap_pin_lo};
         pin_s2 <= pin_s1;
      end
   end

   assign {rstpin_s, sel_s, sclk_s, sdin_s, strap_s} = pin_s2;

   // Edge detection on the synchronised link
   logic sclk_q;
   logic sel_q;
   logic fall;
   logic frame_end;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_q <= 1'b1;
         sel_q  <= 1'b1;
      end else begin
         sclk_q <= sclk_s;
         sel_q  <= sel_s;
      end
   end

   assign fall      = sclk_q & ~sclk_s;
   assign frame_end = ~sel_q & sel_s;

   // Shift register keeps the last 32 bits; the bit count saturates at 63
   logic [31:0] sh;
   logic  [5:0] cnt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sh  <= 32'h0;
         cnt <= 6'h0;
      end else if (sel_s) begin
         cnt <= 6'h0;
      end else if (fall) begin
         sh <= {sh[30:0], sdin_s}; // [R16]
         if (cnt != 6'h3f)
            cnt <= cnt + 6'h1;
      end
   end

   // Frame decode
   logic [23:0] frm;
   logic        len_ok;
   logic        addr_ok;
   logic        apply;
   logic  [2:0] grp;
   logic  [1:0] ch;
   logic  [2:0] control_register_select;
   logic [15:0] dat;
   logic        sw_reset;
   logic        soft_rst;

   // The check byte itself is not verified; only the length changes
   assign frm    = check_on ? sh[31:CHECK_BITS] : sh[23:0]; // [R9]
   assign len_ok = check_on ? (cnt == 6'(FRAME_CHK_BITS))
                            : (cnt == 6'(FRAME_BITS)); // [R9] [R16]
   assign addr_ok = {frm[POS_DEV_HI], frm[POS_DEV_LO]} == strap_s; // [R11]
   assign grp  = frm[POS_GRP_HI:POS_GRP_LO]; // [R10]
   assign ch   = frm[POS_CH_HI:POS_CH_LO]; // [R15]
   assign control_register_select = frm[POS_CONTROL_REGISTER_SELECT_HI:POS_CONTROL_REGISTER_SELECT_LO]; // [R13]
   assign dat  = frm[15:0];
   // Read frames have no readback path here and are dropped
   assign apply = frame_end & len_ok & addr_ok & ~frm[POS_RW]; // [R10]
   assign sw_reset = apply & (grp == GRP_CTRL) & (control_register_select == CONTROL_REGISTER_SELECT_SW)
                     & (dat[11:0] == SW_RESET_KEY);
   assign soft_rst = ~rstpin_s | sw_reset;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_applied <= 1'b0;
         frame_dropped <= 1'b0;
      end else begin
         frame_applied <= apply;
         frame_dropped <= frame_end & ~apply; // [R11]
      end
   end

   // Register file
   logic [15:0] code_r [4];
   logic [15:0] gain_r [4];
   logic [15:0] ofs_r  [4];
   logic [15:0] clr_r  [4];
   logic [15:0] ctl_r  [4];
   logic [15:0] slew_r [4];
   logic [15:0] ctl_dat;

   assign ctl_dat = {3'h0, dat[12:0]};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 4; i++) begin
            code_r[i] <= RST_CODE;
            gain_r[i] <= RST_GAIN;
            ofs_r[i]  <= RST_OFS;
            clr_r[i]  <= RST_CLR;
            ctl_r[i]  <= RST_CTRL;
            slew_r[i] <= RST_CTRL;
         end
         main_ctrl <= RST_CTRL;
         dcdc_ctrl <= RST_CTRL;
         check_on  <= 1'b0;
      end else if (soft_rst) begin
         for (int i = 0; i < 4; i++) begin
            code_r[i] <= RST_CODE;
            gain_r[i] <= RST_GAIN;
            ofs_r[i]  <= RST_OFS;
            clr_r[i]  <= RST_CLR;
            ctl_r[i]  <= RST_CTRL;
            slew_r[i] <= RST_CTRL;
         end
         main_ctrl <= RST_CTRL;
         dcdc_ctrl <= RST_CTRL;
         check_on  <= 1'b0;
      end else if (apply) begin
         unique case (grp)
            GRP_CODE:     code_r[ch] <= dat; // [R12]
            GRP_GAIN:     gain_r[ch] <= dat; // [R12]
            GRP_GAIN_ALL: begin
               for (int i = 0; i < 4; i++)
                  gain_r[i] <= dat; // [R12]
            end
            GRP_OFS:      ofs_r[ch] <= dat; // [R14]
            GRP_OFS_ALL:  begin
               for (int i = 0; i < 4; i++)
                  ofs_r[i] <= dat; // [R14]
            end
            GRP_CLR:      clr_r[ch] <= dat; // [R14]
            GRP_CTRL: begin
               unique case (control_register_select) // [R13]
                  CONTROL_REGISTER_SELECT_MAIN:   main_ctrl <= ctl_dat;
                  CONTROL_REGISTER_SELECT_DACCTL: ctl_r[ch] <= ctl_dat;
                  CONTROL_REGISTER_SELECT_SW:     check_on  <= dat[POS_CHK_EN];
                  CONTROL_REGISTER_SELECT_DCDC:   dcdc_ctrl <= ctl_dat;
                  CONTROL_REGISTER_SELECT_SLEW:   slew_r[ch] <= ctl_dat;
                  default:     ;
               endcase
            end
            // Group 001 is unassigned and ignored
            default: ;
         endcase
      end
   end

   // Calibration timer per channel, restarted by every code write
   logic [CW-1:0] cal_cnt [4];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 4; i++)
            cal_cnt[i] <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (soft_rst)
               cal_cnt[i] <= '0;
            else if (apply && grp == GRP_CODE && ch == 2'(i))
               cal_cnt[i] <= CW'(CAL_CYC); // [R4]
            else if (cal_cnt[i] != '0)
               cal_cnt[i] <= cal_cnt[i] - CW'(1);
         end
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_out
      assign chan_code[16*g +: 16]   = code_r[g];
      assign chan_gain[16*g +: 16]   = gain_r[g];
      assign chan_offset[16*g +: 16] = ofs_r[g];
      assign chan_clear[16*g +: 16]  = clr_r[g];
      assign chan_ctrl[16*g +: 16]   = ctl_r[g];
      assign chan_slew[16*g +: 16]   = slew_r[g];
      assign cal_busy[g]             = cal_cnt[g] != '0; // [R4]
   end
endmodule : dfd_dev

// ### dfd_host.sv
/*
 * Host end: AHB-Lite slave whose frame register sends one frame over the
 * link, guarding the setup sequence, plus a hardware reset pulse.
 * Assumes one AHB-Lite master, single word transfers; the device end
 * samples data on falling serial clock edges.
 */
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module dfd_host
   import dfd_pkg::*;
#(
   parameter int WAIT_CYC = dfd_pkg::OUT_WAIT_CYCLES
) (
   // System
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic  [1:0] htrans,
   input  wire logic        hwrite,
   input  wire logic  [2:0] hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Link
   dfd_link_if.host         link
);
   import dfd_pkg::*;

   localparam int WW = $clog2(WAIT_CYC + 1);

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_HOLD  = 3'b001,
      S_SHIFT = 3'b010,
      S_TAIL  = 3'b011,
      S_RST   = 3'b100
   } dfd_st_t;

   dfd_st_t     st;
   logic        a_vld;
   logic        a_wr;
   logic  [7:0] a_addr;
   logic [23:0] last_frame;
   logic        chk;
   logic  [7:0] chk_code;
   logic        reset_done;
   logic        dcdc_done;
   logic        refused;
   logic  [3:0] code_seen;
   logic [WW-1:0] wait_cnt [4];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture; read data registered for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_vld  <= 1'b0;
         a_wr   <= 1'b0;
         a_addr <= 8'h0;
         hrdata <= 32'h0;
      end else begin
         a_vld  <= hsel & hready & htrans[1];
         a_wr   <= hwrite;
         a_addr <= haddr[7:0];
         if (hsel & hready & htrans[1] & ~hwrite) begin
            unique case (haddr[7:0])
               A_FRAME:  hrdata <= {8'h0, last_frame};
               A_STATUS: hrdata <= {28'h0, refused, dcdc_done,
                                    reset_done, st != S_IDLE};
               A_CTRL:   hrdata <= {16'h0, chk_code, 7'h0, chk};
               default:  hrdata <= 32'h0;
            endcase
         end
      end
   end

   logic wr_frame;
   logic wr_status;
   logic wr_ctrl;

   assign wr_frame  = a_vld & a_wr & (a_addr == A_FRAME);
   assign wr_status = a_vld & a_wr & (a_addr == A_STATUS);
   assign wr_ctrl   = a_vld & a_wr & (a_addr == A_CTRL);

   // Classify the frame being written
   logic [2:0] w_grp;
   logic [2:0] w_control_register_select;
   logic [1:0] w_ch;
   logic       w_swrst;
   logic       w_dcdc;
   logic       w_dacctl;
   logic       w_code;
   logic       w_outon;
   logic       w_ok;

   assign w_grp    = hwdata[POS_GRP_HI:POS_GRP_LO];
   assign w_control_register_select   = hwdata[POS_CONTROL_REGISTER_SELECT_HI:POS_CONTROL_REGISTER_SELECT_LO];
   assign w_ch     = hwdata[POS_CH_HI:POS_CH_LO];
   assign w_swrst  = (w_grp == GRP_CTRL) & (w_control_register_select == CONTROL_REGISTER_SELECT_SW)
                     & (hwdata[11:0] == SW_RESET_KEY);
   assign w_dcdc   = (w_grp == GRP_CTRL) & (w_control_register_select == CONTROL_REGISTER_SELECT_DCDC);
   assign w_dacctl = (w_grp == GRP_CTRL) & (w_control_register_select == CONTROL_REGISTER_SELECT_DACCTL);
   assign w_code   = w_grp == GRP_CODE;
   assign w_outon  = w_dacctl & hwdata[POS_OUT_ON];
   assign w_ok = (st == S_IDLE) & ~hwdata[POS_RW]
               & (reset_done | w_swrst) // [R1]
               & ~(w_dacctl & ~dcdc_done) // [R2] [R8]
               & ~(w_outon & ~code_seen[w_ch]); // [R3] [R6]

   // Sequence tracking; refused is set over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reset_done <= 1'b0;
         dcdc_done  <= 1'b0;
         code_seen  <= 4'h0;
         refused    <= 1'b0;
      end else begin
         if (wr_frame & ~w_ok)
            refused <= 1'b1;
         else if (wr_status & hwdata[ST_REFUSED])
            refused <= 1'b0;
         if (st == S_RST || (wr_frame && w_ok && w_swrst)) begin
            reset_done <= 1'b1; // [R1]
            dcdc_done  <= 1'b0;
            code_seen  <= 4'h0;
         end else if (wr_frame & w_ok) begin
            if (w_dcdc)
               dcdc_done <= 1'b1; // [R2]
            if (w_code)
               code_seen[w_ch] <= 1'b1;
            // Range change: output off demands a fresh code
            else if (w_dacctl & ~hwdata[POS_OUT_ON])
               code_seen[w_ch] <= 1'b0; // [R7]
         end
      end
   end

   // Settling timers started by each code frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 4; i++)
            wait_cnt[i] <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_frame && w_ok && w_code && w_ch == 2'(i))
               wait_cnt[i] <= WW'(WAIT_CYC); // [R5]
            else if (wait_cnt[i] != '0)
               wait_cnt[i] <= wait_cnt[i] - WW'(1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk      <= 1'b0;
         chk_code <= 8'h0;
      end else if (wr_ctrl) begin
         chk      <= hwdata[CT_CHK];
         chk_code <= hwdata[CT_CODE_LO +: 8];
      end
   end

   // Serial engine
   logic  [2:0] dcnt;
   logic        tick;
   logic  [5:0] bcnt;
   logic [31:0] sh;
   logic  [1:0] hold_ch;
   logic  [5:0] nbits;

   assign tick  = dcnt == 3'(SCLK_HALF - 1);
   assign nbits = chk ? 6'(FRAME_CHK_BITS) : 6'(FRAME_BITS); // [R9]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st           <= S_IDLE;
         dcnt         <= 3'h0;
         bcnt         <= 6'h0;
         sh           <= 32'h0;
         hold_ch      <= 2'h0;
         last_frame   <= 24'h0;
         link.sclk    <= 1'b1;
         link.sync_n  <= 1'b1;
         link.reset_n <= 1'b1;
      end else begin
         // Held at zero while waiting, so the first edge keeps its setup
         dcnt <= (st == S_IDLE || st == S_HOLD || tick) ? 3'h0 : dcnt + 3'h1;
         unique case (st)
            S_IDLE: begin
               bcnt <= 6'h0;
               if (wr_ctrl & hwdata[CT_HWRST]) begin
                  link.reset_n <= 1'b0; // [R1]
                  st           <= S_RST;
               end else if (wr_frame & w_ok) begin
                  last_frame <= hwdata[23:0];
                  sh         <= {hwdata[23:0], chk_code}; // [R10]
                  hold_ch    <= w_ch;
                  st         <= w_outon ? S_HOLD : S_SHIFT;
                  link.sync_n <= w_outon;
               end
            end
            S_HOLD: begin
               if (wait_cnt[hold_ch] == '0) begin
                  link.sync_n <= 1'b0; // [R5]
                  st          <= S_SHIFT;
               end
            end
            S_SHIFT: begin
               if (tick) begin
                  link.sclk <= ~link.sclk;
                  if (!link.sclk) begin
                     sh   <= {sh[30:0], 1'b0}; // [R10]
                     bcnt <= bcnt + 6'h1;
                     if (bcnt == nbits - 6'h1)
                        st <= S_TAIL;
                  end
               end
            end
            S_TAIL: begin
               if (tick) begin
                  link.sync_n <= 1'b1;
                  st          <= S_IDLE;
               end
            end
            S_RST: begin
               bcnt <= bcnt + 6'h1;
               if (bcnt == 6'(HW_RST_CYCLES - 1)) begin
                  link.reset_n <= 1'b1;
                  st           <= S_IDLE;
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   assign link.sdin = sh[31];
endmodule : dfd_host

// ### dfd_link_asserts.sv
/*
 * Checker for the serial link between host and converter ends.
 * Assumes plain link signals sampled on hclk; hresetn resets both ends.
 */
`timescale 1ns/1ps
module dfd_link_asserts (
   // System
   input wire logic hclk,
   input wire logic hresetn,
   // Link
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdin,
   input wire logic reset_n
);
   logic [5:0] fall_cnt;

   // Cleared while idle so a dropped frame never leaks into the next
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fall_cnt <= 6'h00;
      end else if (sync_n) begin
         fall_cnt <= 6'h00;
      end else if ($fell(sclk)) begin
         fall_cnt <= fall_cnt + 6'h01;
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence open_s;
      sclk [*4] ##1 !sclk;
   endsequence
   sequence pin_low_s;
      (!reset_n) [*8] ##1 reset_n;
   endsequence

   idle_clock_a: assert property (sync_n |-> sclk)
      else $error("serial clock not high while idle");
   half_period_a: assert property (
      !sync_n && $changed(sclk) |=> $stable(sclk) [*3])
      else $error("serial clock phase too short");
   data_hold_a: assert property (!sync_n && !sclk |-> $stable(sdin))
      else $error("data moved while clock low");
   frame_len_a: assert property (
      $rose(sync_n) |-> fall_cnt == 6'h18 || fall_cnt == 6'h20)
      else $error("frame length not 24 or 32");
   write_bit_a: assert property ($fell(sync_n) |-> !sdin)
      else $error("first bit is not a write");
   frame_open_a: assert property ($fell(sync_n) |-> open_s)
      else $error("first falling edge misplaced");
   frame_close_a: assert property (
      $rose(sync_n) |-> $past(sclk, 4) && !$past(sclk, 5))
      else $error("frame end misplaced");
   pin_pulse_a: assert property ($fell(reset_n) |-> pin_low_s)
      else $error("reset pin pulse not 8 cycles");
endmodule : dfd_link_asserts

// ### dfd_link_if.sv
/*
 * Serial link between host and converter: serial clock, frame select,
 * serial data and the hardware reset pin. All wires one-way.
 * Assumes the host makes the serial clock; the device samples it.
 */
`timescale 1ns/1ps
interface dfd_link_if;
   logic sclk;
   logic sync_n;
   logic sdin;
   logic reset_n;
   modport host (output sclk, output sync_n, output sdin, output reset_n);
   modport dev  (input sclk, input sync_n, input sdin, input reset_n);
endinterface : dfd_link_if

// ### dfd_pkg.sv
/*
 * Shared constants for the serial frame link between a host controller
 * and a quad-channel output converter: frame fields, register groups,
 * control selects, reset values, host register map and link timing.
 * Assumes a 50 MHz system clock on both ends.
 */
package dfd_pkg;
   // Frame layout
   localparam int FRAME_BITS      = 24;
   localparam int FRAME_CHK_BITS  = 32;
   localparam int CHECK_BITS      = 8;
   localparam int POS_RW          = 23;
   localparam int POS_DEV_HI      = 22;
   localparam int POS_DEV_LO      = 21;
   localparam int POS_GRP_HI      = 20;
   localparam int POS_GRP_LO      = 18;
   localparam int POS_CH_HI       = 17;
   localparam int POS_CH_LO       = 16;
   localparam int POS_CONTROL_REGISTER_SELECT_HI     = 15;
   localparam int POS_CONTROL_REGISTER_SELECT_LO     = 13;
   // Register groups
   localparam logic [2:0] GRP_CODE     = 3'h0;
   localparam logic [2:0] GRP_GAIN     = 3'h2;
   localparam logic [2:0] GRP_GAIN_ALL = 3'h3;
   localparam logic [2:0] GRP_OFS      = 3'h4;
   localparam logic [2:0] GRP_OFS_ALL  = 3'h5;
   localparam logic [2:0] GRP_CLR      = 3'h6;
   localparam logic [2:0] GRP_CTRL     = 3'h7;
   // Control register selects
   localparam logic [2:0] CONTROL_REGISTER_SELECT_MAIN    = 3'h0;
   localparam logic [2:0] CONTROL_REGISTER_SELECT_DACCTL  = 3'h1;
   localparam logic [2:0] CONTROL_REGISTER_SELECT_SW      = 3'h2;
   localparam logic [2:0] CONTROL_REGISTER_SELECT_DCDC    = 3'h3;
   localparam logic [2:0] CONTROL_REGISTER_SELECT_SLEW    = 3'h4;
   // Control field positions
   localparam int POS_OUT_ON       = 6;
   localparam int POS_CONV_ON      = 7;
   localparam int POS_INT_EN       = 8;
   localparam int POS_CHK_EN       = 12;
   localparam logic [11:0] SW_RESET_KEY = 12'h555;
   // Values after reset
   localparam logic [15:0] RST_CODE = 16'h0000;
   localparam logic [15:0] RST_GAIN = 16'hffff;
   localparam logic [15:0] RST_OFS  = 16'h8000;
   localparam logic [15:0] RST_CLR  = 16'h0000;
   localparam logic [15:0] RST_CTRL = 16'h0000;
   // Timing
   localparam int CLK_MHZ         = 50;
   localparam int OUT_WAIT_US     = 200;
   localparam int OUT_WAIT_CYCLES = OUT_WAIT_US * CLK_MHZ;
   localparam int CAL_CYCLES      = 64;
   localparam int SCLK_HALF       = 4;
   localparam int HW_RST_CYCLES   = 8;
   // Host register map
   localparam logic [7:0] A_FRAME  = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_CTRL   = 8'h08;
   localparam int ST_BUSY    = 0;
   localparam int ST_RSTDONE = 1;
   localparam int ST_DCDC    = 2;
   localparam int ST_REFUSED = 3;
   localparam int CT_CHK     = 0;
   localparam int CT_HWRST   = 1;
   localparam int CT_CODE_LO = 8;
endpackage : dfd_pkg

// ### testbench.sv
/*
 * Top bench: AHB-Lite master drives the host end, device end observed.
 * Assumes 50 MHz hclk and straps fixed at hi=1, lo=0.
 */
`timescale 1ns/1ps
module testbench;
   import dfd_pkg::*;
   localparam int WAIT_T = 1000;
   localparam int CAL_T  = 400;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic  [1:0] htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   logic [63:0] code, gain, ofs, clr, ctl, slew;
   logic [15:0] mctl, dctl;
   logic  [3:0] cal;
   logic        chk_on;
   logic [31:0] st;
   logic  [2:0] hsize;
   logic        applied;
   logic        dropped;
   int          n_apply;
   int          n_drop;
   int          error_cnt;
   int          samples_checked;
   realtime     t0;

   dfd_link_if dfd_link_if_i ();
   dfd_host #(.WAIT_CYC(WAIT_T)) dfd_host_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .link(dfd_link_if_i.host));
   dfd_dev #(.CAL_CYC(CAL_T)) dfd_dev_i (
      .hclk(hclk), .hresetn(hresetn), .link(dfd_link_if_i.dev),
      .strap_pin_hi(1'b1), .strap_pin_lo(1'b0), .chan_code(code),
      .chan_gain(gain), .chan_offset(ofs), .chan_clear(clr),
      .chan_ctrl(ctl), .chan_slew(slew), .main_ctrl(mctl),
      .dcdc_ctrl(dctl), .cal_busy(cal), .check_on(chk_on),
      .frame_applied(applied), .frame_dropped(dropped));
   dfd_link_asserts dfd_link_asserts_i (
      .hclk(hclk), .hresetn(hresetn), .sclk(dfd_link_if_i.sclk),
      .sync_n(dfd_link_if_i.sync_n), .sdin(dfd_link_if_i.sdin),
      .reset_n(dfd_link_if_i.reset_n));

   always #10 hclk = ~hclk;

   // Count the one-cycle frame pulses of the device end
   always @(posedge hclk) begin
      if (applied === 1'b1)
         n_apply <= n_apply + 1;
      if (dropped === 1'b1)
         n_drop <= n_drop + 1;
   end

   function automatic logic [23:0] fr(input logic [2:0] g,
                                      input logic [1:0] c,
                                      input logic [15:0] d);
      return {1'b0, 2'b10, g, c, d};
   endfunction : fr

   task automatic final_report;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string n, input logic [63:0] e,
                      input logic [63:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic wt;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         error_cnt++;
         final_report();
      end
   endtask : wt

   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      wt();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      st = hrdata;
   endtask : ahb

   // Sends a frame, waits for idle, checks whether it was refused
   task automatic snd(input logic [23:0] f, input logic r);
      int n;
      n = 0;
      ahb(1'b1, A_FRAME, {8'h0, f});
      repeat (3) @(posedge hclk);
      do begin
         ahb(1'b0, A_STATUS, 32'h0);
         n++;
      end while (st[ST_BUSY] !== 1'b0 && n < 3000);
      if (st[ST_BUSY] !== 1'b0) begin
         error_cnt++;
         final_report();
      end
      // Device acts a few cycles after the select rises; let it settle
      repeat (6) @(posedge hclk);
      chk("refused", r, st[ST_REFUSED]);
      if (st[ST_REFUSED] === 1'b1) begin
         ahb(1'b1, A_STATUS, 32'h8);
      end
   endtask : snd

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("gain", {4{16'hffff}}, gain);
      chk("ofs", {4{16'h8000}}, ofs);
      snd(fr(GRP_CODE, 2'h1, 16'h1111), 1'b1);
      chk("code", 64'h0, code);
      ahb(1'b1, A_CTRL, 32'h2);
      repeat (12) @(posedge hclk);
      ahb(1'b0, A_STATUS, 32'h0);
      chk("rst done", 1'b1, st[ST_RSTDONE]);
      snd(fr(GRP_CTRL, 2'h1, {CONTROL_REGISTER_SELECT_DACCTL, 13'h0180}), 1'b1);
      snd(fr(GRP_CTRL, 2'h0, {CONTROL_REGISTER_SELECT_DCDC, 13'h0123}), 1'b0);
      chk("dcdc", 16'h0123, dctl);
      ahb(1'b0, A_STATUS, 32'h0);
      chk("dcdc done", 1'b1, st[ST_DCDC]);
      snd(fr(GRP_CTRL, 2'h1, {CONTROL_REGISTER_SELECT_DACCTL, 13'h0180}), 1'b0);
      chk("ctl", 64'h0180_0000, ctl);
      snd(fr(GRP_CTRL, 2'h1, {CONTROL_REGISTER_SELECT_DACCTL, 13'h01c0}), 1'b1);
      t0 = $realtime;
      snd(fr(GRP_CODE, 2'h1, 16'h8000), 1'b0);
      chk("code", 64'h8000_0000, code);
      chk("cal", 4'h2, cal);
      snd(fr(GRP_CTRL, 2'h1, {CONTROL_REGISTER_SELECT_DACCTL, 13'h01c0}), 1'b0);
      chk("ctl on", 64'h01c0_0000, ctl);
      chk("wait", 1'b1, ($realtime - t0) >= WAIT_T * 20.0);
      chk("cal end", 4'h0, cal);
      snd(fr(GRP_CTRL, 2'h1, {CONTROL_REGISTER_SELECT_DACCTL, 13'h0180}), 1'b0);
      snd(fr(GRP_CTRL, 2'h1, {CONTROL_REGISTER_SELECT_DACCTL, 13'h01c0}), 1'b1);
      chk("dcdc kept", 16'h0123, dctl);
      snd(fr(GRP_GAIN, 2'h2, 16'h1234), 1'b0);
      chk("gain", {16'hffff, 16'h1234, 32'hffffffff}, gain);
      snd(fr(GRP_GAIN_ALL, 2'h0, 16'h5555), 1'b0);
      chk("gain all", {4{16'h5555}}, gain);
      snd(fr(GRP_OFS, 2'h3, 16'h0abc), 1'b0);
      chk("ofs", {16'h0abc, {3{16'h8000}}}, ofs);
      snd(fr(GRP_OFS_ALL, 2'h1, 16'h0101), 1'b0);
      chk("ofs all", {4{16'h0101}}, ofs);
      snd(fr(GRP_CLR, 2'h0, 16'h7777), 1'b0);
      chk("clr", 64'h7777, clr);
      ahb(1'b0, A_FRAME, 32'h0);
      chk("last frame", {8'h0, fr(GRP_CLR, 2'h0, 16'h7777)}, st);
      snd({1'b0, 2'b01, GRP_CLR, 2'h0, 16'h1111}, 1'b0);
      chk("clr kept", 64'h7777, clr);
      snd({1'b1, 2'b10, GRP_CODE, 2'h0, 16'h0001}, 1'b1);
      snd(fr(3'h1, 2'h0, 16'h2222), 1'b0);
      chk("code kept", 64'h8000_0000, code);
      snd(fr(GRP_CTRL, 2'h2, {CONTROL_REGISTER_SELECT_SLEW, 13'h0005}), 1'b0);
      chk("slew", 64'h0005_0000_0000, slew);
      snd(fr(GRP_CTRL, 2'h0, {CONTROL_REGISTER_SELECT_MAIN, 13'h0042}), 1'b0);
      chk("main", 16'h0042, mctl);
      snd(fr(GRP_CTRL, 2'h0, {CONTROL_REGISTER_SELECT_SW, 13'h1000}), 1'b0);
      chk("check on", 1'b1, chk_on);
      snd(fr(GRP_CODE, 2'h0, 16'h9999), 1'b0);
      chk("short frame", 64'h8000_0000, code);
      ahb(1'b1, A_CTRL, 32'h1);
      ahb(1'b0, A_CTRL, 32'h0);
      chk("ctrl", 32'h1, st);
      snd(fr(GRP_CODE, 2'h3, 16'h4321), 1'b0);
      chk("long frame", 64'h4321_0000_8000_0000, code);
      snd(fr(GRP_CTRL, 2'h0, {CONTROL_REGISTER_SELECT_SW, 1'b0, 12'h555}), 1'b0);
      chk("sw rst gain", {4{16'hffff}}, gain);
      chk("sw rst ctl", 64'h0, ctl);
      chk("sw rst chk", 1'b0, chk_on);
      chk("applied", 64'h10, n_apply);
      chk("dropped", 64'h2, n_drop);
      final_report();
   end
endmodule : testbench
